// ===== rtl/vectored_interrupt_controller.sv
/*
 Vectored interrupt controller: request latches, priority registers,
 global enable, AHB-Lite register slave and the request to the core.
 Assumes a core that pulses CORE_ACK_I for one cycle while
 INT_REQUEST_O is high, and peripherals that pulse their requests.
*/
`timescale 1ns/100ps
module vectored_interrupt_controller (
   input  wire logic        CORE_CLK_I,
   input  wire logic        RSTN_I,
   input  wire logic        HSEL_I,
   input  wire logic [31:0] HADDR_I,
   input  wire logic [1:0]  HTRANS_I,
   input  wire logic        HWRITE_I,
   input  wire logic [2:0]  HSIZE_I,
   input  wire logic [31:0] HWDATA_I,
   input  wire logic        HREADY_I,
   output logic      [31:0] HRDATA_O,
   output logic             HREADYOUT_O,
   output logic             HRESP_O,
   input  wire logic        TIMER_ONE_REQUEST_I,
   input  wire logic        TIMER_ZERO_REQUEST_I,
   input  wire logic        SERIAL_RECEIVE_REQUEST_I,
   input  wire logic        SERIAL_TRANSMIT_REQUEST_I,
   input  wire logic        CONVERTER_REQUEST_I,
   input  wire logic        PORTA_PIN7_OR_LOWVOLT_REQUEST_I,
   input  wire logic        PORTA_PIN6_OR_COMPARATOR_REQUEST_I,
   input  wire logic [5:0]  PORTA_PIN_REQUEST_I,
   input  wire logic [3:0]  PORTC_PIN_REQUEST_I,
   input  wire logic        WATCHDOG_TIMEOUT_I,
   input  wire logic        WATCHDOG_INT_ENABLE_I,
   input  wire logic        PRIMARY_OSC_FAIL_I,
   input  wire logic        WATCHDOG_OSC_FAIL_I,
   input  wire logic        ENABLE_INTERRUPTS_INSTRUCTION_I,
   input  wire logic        DISABLE_INTERRUPTS_INSTRUCTION_I,
   input  wire logic        RETURN_FROM_INTERRUPT_INSTRUCTION_I,
   input  wire logic        TRAP_INSTRUCTION_I,
   input  wire logic        ILLEGAL_INSTRUCTION_TRAP_I,
   input  wire logic        CORE_ACK_I,
   output logic             INT_REQUEST_O,
   output logic      [15:0] INT_VECTOR_O,
   output logic             GLOBAL_INT_ENABLE_O
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] rev8(input logic [7:0] a);
      for (int k = 0; k < 8; k++) begin
         rev8[k] = a[7-k];
      end
   endfunction

   function automatic logic [23:0] flat(input logic [7:0] a0,
                                        input logic [7:0] a1,
                                        input logic [7:0] a2);
      flat = {rev8(a2), rev8(a1), rev8(a0)};
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0]  req        [3];
   logic [7:0]  prio_high  [3];
   logic [7:0]  prio_low   [3];
   logic [7:0]  next_req   [3];
   logic [7:0]  next_ph    [3];
   logic [7:0]  next_pl    [3];
   logic        global_int_enable;
   logic        next_gie;
   logic [1:0]  trap_pend;
   logic [1:0]  next_trap;
   logic [4:0]  sel;
   logic [4:0]  next_sel;
   logic        int_req;
   logic        next_int_req;
   logic [15:0] vec;
   logic [15:0] next_vec;
   logic        dp_write;
   logic        next_dp_write;
   logic [11:0] dp_idx;
   logic [11:0] next_dp_idx;
   logic [31:0] hrdata;
   logic [31:0] next_hrdata;

   logic [7:0]  hw         [3];
   logic [7:0]  ack_clr    [3];
   logic [23:0] hw_flat;
   logic [23:0] ack_flat;
   logic        wr_en;
   logic [7:0]  wbyte;
   logic        ap_take;
   logic        ap_ok;
   logic [11:0] ap_idx;
   logic        gie_set;
   logic        gie_clr;
   logic        wdt_active;
   logic        found;

   arb_if arb ();

   vic_arbiter u_arbiter (
      .bus (arb.arb)
   );

   // ----------------------------------------------------------------
   // Request sources
   // ----------------------------------------------------------------
   // Each pulse sets one latch per cycle it is high; a level would keep
   // re-arming the bit after acknowledge.
   always_comb begin
      hw[0] = {1'b0, TIMER_ONE_REQUEST_I, TIMER_ZERO_REQUEST_I,
               SERIAL_RECEIVE_REQUEST_I, SERIAL_TRANSMIT_REQUEST_I,
               2'h0, CONVERTER_REQUEST_I};
      hw[1] = {PORTA_PIN7_OR_LOWVOLT_REQUEST_I,
               PORTA_PIN6_OR_COMPARATOR_REQUEST_I,
               PORTA_PIN_REQUEST_I};
      hw[2] = {4'h0, PORTC_PIN_REQUEST_I};
      hw_flat = flat(hw[0], hw[1], hw[2]);
   end

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   // Zero wait states; read data is taken from next values so a read
   // right after a write to the same word sees the written value.
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O     = vic_pkg::HRESP_OKAY;
   assign HRDATA_O    = hrdata;

   always_comb begin
      ap_take = HSEL_I && HTRANS_I[1] && HREADY_I;
      ap_ok   = (HADDR_I[31:14] == vic_pkg::ADDR_HI_ZERO) &&
                (HADDR_I[1:0] == 2'h0);
      ap_idx  = ap_ok ? HADDR_I[13:2] : 12'h000;
      wr_en   = dp_write;
      wbyte   = HWDATA_I[7:0];
      next_dp_write = ap_take && HWRITE_I && ap_ok;
      next_dp_idx   = ap_take ? ap_idx : dp_idx;
   end

   // ----------------------------------------------------------------
   // Request, priority and enable registers
   // ----------------------------------------------------------------
   always_comb begin
      ack_flat = 24'h00_0000;
      if (CORE_ACK_I && int_req && (sel < 5'(vic_pkg::NUM_SRC))) begin
         ack_flat = 24'h00_0001 << sel;
      end
      ack_clr[0] = rev8(ack_flat[7:0]);
      ack_clr[1] = rev8(ack_flat[15:8]);
      ack_clr[2] = rev8(ack_flat[23:16]);
      for (int g = 0; g < vic_pkg::NUM_GROUPS; g++) begin
         next_req[g] = req[g] & ~ack_clr[g];
         next_ph[g]  = prio_high[g];
         next_pl[g]  = prio_low[g];
         if (wr_en && dp_idx == vic_pkg::IDX_REQ[g]) begin
            next_req[g] = wbyte;
         end
         if (wr_en && dp_idx == vic_pkg::IDX_PH[g]) begin
            next_ph[g] = wbyte & vic_pkg::GROUP_MASK[g];
         end
         if (wr_en && dp_idx == vic_pkg::IDX_PL[g]) begin
            next_pl[g] = wbyte & vic_pkg::GROUP_MASK[g];
         end
         // Hardware set is applied last so it beats a write or an ack
         next_req[g] = (next_req[g] | hw[g]) &
                       vic_pkg::GROUP_MASK[g];
      end
   end

   always_comb begin
      gie_set = ENABLE_INTERRUPTS_INSTRUCTION_I ||
                RETURN_FROM_INTERRUPT_INSTRUCTION_I ||
                (wr_en && dp_idx == vic_pkg::IDX_CTRL &&
                 wbyte[vic_pkg::CTRL_GIE_BIT]);
      gie_clr = DISABLE_INTERRUPTS_INSTRUCTION_I || CORE_ACK_I ||
                TRAP_INSTRUCTION_I || ILLEGAL_INSTRUCTION_TRAP_I ||
                PRIMARY_OSC_FAIL_I || WATCHDOG_OSC_FAIL_I ||
                (wr_en && dp_idx == vic_pkg::IDX_CTRL &&
                 !wbyte[vic_pkg::CTRL_GIE_BIT]);
      next_gie = gie_set ? 1'b1 :
                 gie_clr ? 1'b0 : global_int_enable;
      // Oscillator traps bypass the request registers
      next_trap = trap_pend;
      if (CORE_ACK_I && int_req && sel == vic_pkg::SEL_POSC) begin
         next_trap[0] = 1'b0;
      end
      if (CORE_ACK_I && int_req && sel == vic_pkg::SEL_WOSC) begin
         next_trap[1] = 1'b0;
      end
      next_trap = next_trap |
                  {WATCHDOG_OSC_FAIL_I, PRIMARY_OSC_FAIL_I};
   end

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   always_comb begin
      next_hrdata = hrdata;
      if (ap_take && !HWRITE_I) begin
         next_hrdata = 32'h0000_0000;
         for (int g = 0; g < vic_pkg::NUM_GROUPS; g++) begin
            if (ap_idx == vic_pkg::IDX_REQ[g]) begin
               next_hrdata[7:0] = next_req[g];
            end
            if (ap_idx == vic_pkg::IDX_PH[g]) begin
               next_hrdata[7:0] = next_ph[g];
            end
            if (ap_idx == vic_pkg::IDX_PL[g]) begin
               next_hrdata[7:0] = next_pl[g];
            end
         end
         if (ap_idx == vic_pkg::IDX_CTRL) begin
            next_hrdata[vic_pkg::CTRL_GIE_BIT] = next_gie;
         end
      end
   end

   // ----------------------------------------------------------------
   // Selection and request to the core
   // ----------------------------------------------------------------
   assign arb.pending   = flat(req[0], req[1], req[2]);
   assign arb.prio_high = flat(prio_high[0], prio_high[1], prio_high[2]);
   assign arb.prio_low  = flat(prio_low[0], prio_low[1], prio_low[2]);

   // Watchdog is a level: it stays selected while the timeout and its own enable last and global enable is set
   assign wdt_active = WATCHDOG_TIMEOUT_I && WATCHDOG_INT_ENABLE_I;

   always_comb begin
      found    = 1'b1;
      next_sel = vic_pkg::SEL_NONE;
      if (wdt_active && global_int_enable) begin
         next_sel = vic_pkg::SEL_WDT;
      end else if (trap_pend[0]) begin
         next_sel = vic_pkg::SEL_POSC;
      end else if (trap_pend[1]) begin
         next_sel = vic_pkg::SEL_WOSC;
      end else if (arb.win_valid && global_int_enable) begin
         next_sel = arb.win_index;
      end else begin
         found = 1'b0;
      end
      unique case (next_sel)
         vic_pkg::SEL_WDT:  next_vec = vic_pkg::VEC_WDT;
         vic_pkg::SEL_POSC: next_vec = vic_pkg::VEC_POSC;
         vic_pkg::SEL_WOSC: next_vec = vic_pkg::VEC_WOSC;
         default:           next_vec = vic_pkg::VEC_BASE +
                                       {10'h000, next_sel, 1'b0};
      endcase
      // Drop for one cycle on ack so the core never sees a stale grant
      next_int_req = found && !CORE_ACK_I;
   end

   assign INT_REQUEST_O       = int_req;
   assign INT_VECTOR_O        = vec;
   assign GLOBAL_INT_ENABLE_O = global_int_enable;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         for (int g = 0; g < 3; g++) begin
            req[g]       <= vic_pkg::RESET_BYTE;
            prio_high[g] <= vic_pkg::RESET_BYTE;
            prio_low[g]  <= vic_pkg::RESET_BYTE;
         end
         global_int_enable <= 1'b0;
         trap_pend <= 2'h0;
         sel       <= vic_pkg::SEL_NONE;
         int_req   <= 1'b0;
         vec       <= 16'h0000;
         dp_write  <= 1'b0;
         dp_idx    <= 12'h000;
         hrdata    <= 32'h0000_0000;
      end else begin
         for (int g = 0; g < 3; g++) begin
            req[g]       <= next_req[g];
            prio_high[g] <= next_ph[g];
            prio_low[g]  <= next_pl[g];
         end
         global_int_enable <= next_gie;
         trap_pend <= next_trap;
         sel       <= next_sel;
         int_req   <= next_int_req;
         vec       <= next_vec;
         dp_write  <= next_dp_write;
         dp_idx    <= next_dp_idx;
         hrdata    <= next_hrdata;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [1:0] max_lvl;
   logic       earlier_same;
   logic [1:0] win_lvl;

   always_comb begin
      max_lvl      = 2'h0;
      earlier_same = 1'b0;
      win_lvl = {arb.prio_high[arb.win_index], arb.prio_low[arb.win_index]};
      for (int i = 0; i < vic_pkg::NUM_SRC; i++) begin
         if (arb.pending[i] &&
             {arb.prio_high[i], arb.prio_low[i]} > max_lvl) begin
            max_lvl = {arb.prio_high[i], arb.prio_low[i]};
         end
         if (arb.pending[i] && i < int'(arb.win_index) &&
             {arb.prio_high[i], arb.prio_low[i]} == win_lvl) begin
            earlier_same = 1'b1;
         end
      end
   end

   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RSTN_I);

   chk_ei_sets_enable: assert property (
      ENABLE_INTERRUPTS_INSTRUCTION_I |=> global_int_enable)
      else $error("enable instruction did not set global enable");
   chk_ack_clears_enable: assert property (
      CORE_ACK_I && !gie_set |=> !global_int_enable && !INT_REQUEST_O)
      else $error("acknowledge did not clear global enable");
   chk_level_order: assert property (
      arb.win_valid |-> win_lvl == max_lvl && max_lvl != 2'h0)
      else $error("winner is not at the highest pending level");
   chk_fixed_order: assert property (
      arb.win_valid |-> !earlier_same)
      else $error("earlier source at same level was passed over");
   chk_wdt_top: assert property (
      wdt_active && global_int_enable && !CORE_ACK_I |=>
      INT_REQUEST_O && INT_VECTOR_O == vic_pkg::VEC_WDT)
      else $error("watchdog did not take the top slot");
   chk_pulse_sets: assert property (
      |hw_flat |=> (arb.pending & $past(hw_flat)) == $past(hw_flat))
      else $error("request pulse did not latch its bit");
   chk_ack_clears_bit: assert property (
      CORE_ACK_I && int_req && sel < 5'h18 && !wr_en &&
      !hw_flat[sel] |=> !arb.pending[$past(sel)])
      else $error("acknowledged request bit still set");
   chk_write_zero: assert property (
      wr_en && dp_idx == vic_pkg::IDX_REQ[0] && wbyte == 8'h00 &&
      hw[0] == 8'h00 |=> req[0] == 8'h00)
      else $error("writing zero did not clear requests");
   chk_no_forward: assert property (
      !global_int_enable && trap_pend == 2'h0 |=> !INT_REQUEST_O)
      else $error("request forwarded while globally disabled");
   chk_reserved_zero: assert property (
      (req[0] & ~vic_pkg::GROUP_MASK[0]) == 8'h00 &&
      (req[2] & ~vic_pkg::GROUP_MASK[2]) == 8'h00)
      else $error("reserved request bit set");

endmodule

// ===== common/vic_pkg.sv
/*
 Constants shared by the interrupt controller and its arbiter: register
 indices, field masks, vector addresses and source codes.
 Assumes a 32-bit AHB-Lite register bus, one aligned word per register.
*/
package vic_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_GROUPS = 3;
   localparam int NUM_SRC    = 24;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [11:0] IDX_REQ [NUM_GROUPS] =
      '{12'h0fc0, 12'h0fc3, 12'h0fc6};
   localparam logic [11:0] IDX_PH  [NUM_GROUPS] =
      '{12'h0fc1, 12'h0fc4, 12'h0fc7};
   localparam logic [11:0] IDX_PL  [NUM_GROUPS] =
      '{12'h0fc2, 12'h0fc5, 12'h0fc8};
   localparam logic [11:0] IDX_CTRL = 12'h0fcf;
   localparam logic [17:0] ADDR_HI_ZERO = 18'h0_0000;

   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] GROUP_MASK [NUM_GROUPS] =
      '{8'h79, 8'hff, 8'h0f};
   localparam logic [7:0] RESET_BYTE   = 8'h00;
   localparam int         CTRL_GIE_BIT = 7;

   // ----------------------------------------------------------------
   // Vectors and selection codes
   // ----------------------------------------------------------------
   localparam logic [15:0] VEC_BASE = 16'h0008;
   localparam logic [15:0] VEC_WDT  = 16'h0004;
   localparam logic [15:0] VEC_POSC = 16'h003a;
   localparam logic [15:0] VEC_WOSC = 16'h003c;
   localparam logic [4:0]  SEL_WDT  = 5'h18;
   localparam logic [4:0]  SEL_POSC = 5'h19;
   localparam logic [4:0]  SEL_WOSC = 5'h1a;
   localparam logic [4:0]  SEL_NONE = 5'h00;

   typedef enum logic [1:0] {
      LVL_OFF   = 2'h0,
      LVL_ONE   = 2'h1,
      LVL_TWO   = 2'h2,
      LVL_THREE = 2'h3
   } level_t;

   // ----------------------------------------------------------------
   // Bus encodings
   // ----------------------------------------------------------------
   localparam logic HRESP_OKAY = 1'h0;

endpackage

// ===== common/arb_if.sv
/*
 Carrier between the controller and its priority arbiter.
 Assumes sources are flattened in vector-table order, index 0 first.
*/
`timescale 1ns/100ps
interface arb_if;
   logic [23:0] pending;
   logic [23:0] prio_high;
   logic [23:0] prio_low;
   logic        win_valid;
   logic [4:0]  win_index;

   modport ctrl (
      output pending,
      output prio_high,
      output prio_low,
      input  win_valid,
      input  win_index
   );

   modport arb (
      input  pending,
      input  prio_high,
      input  prio_low,
      output win_valid,
      output win_index
   );
endinterface

// ===== rtl/vic_arbiter.sv
/*
 Combinational priority arbiter over the flattened request sources.
 Assumes the controller registers the result before it leaves the block.
*/
`timescale 1ns/100ps
module vic_arbiter (
   arb_if.arb bus
);

   function automatic vic_pkg::level_t level_of(input logic h,
                                                input logic l);
      level_of = vic_pkg::level_t'({h, l});
   endfunction

   logic       found;
   logic [4:0] idx;

   // Highest level first, then lowest index inside a level
   always_comb begin
      found = 1'b0;
      idx   = vic_pkg::SEL_NONE;
      for (int lv = 3; lv >= 1; lv--) begin
         for (int i = 0; i < vic_pkg::NUM_SRC; i++) begin
            if (!found && bus.pending[i] &&
                level_of(bus.prio_high[i], bus.prio_low[i]) ==
                vic_pkg::level_t'(lv[1:0])) begin
               found = 1'b1;
               idx   = i[4:0];
            end
         end
      end
      bus.win_valid = found;
      bus.win_index = idx;
   end

endmodule

// ===== bench/core_model.sv
/*
 Behavioural processor core that acknowledges vectored requests.
 Assumes the clock and active-low reset of the controller it faces.
*/
`timescale 1ns/100ps
module core_model (
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic        req_i,
   input  wire logic [15:0] vec_i,
   input  wire logic [1:0]  lag_i,
   output logic             ack_o,
   output logic      [15:0] last_vec_o,
   output int               n_ack_o
);
   logic [1:0] wait_cnt;

   // Ack is one pulse, raised only while the request is seen high;
   // lag_i lets the bench pick a prompt or a slow core
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_o <= 1'b0;
         wait_cnt <= 2'h0;
         last_vec_o <= 16'h0000;
         n_ack_o <= 0;
      end else if (ack_o || !req_i) begin
         ack_o <= 1'b0;
         wait_cnt <= 2'h0;
      end else if (wait_cnt == lag_i) begin
         ack_o <= 1'b1;
         last_vec_o <= vec_i;
         n_ack_o <= n_ack_o + 1;
      end else begin
         wait_cnt <= wait_cnt + 2'h1;
      end
   end
endmodule

// ===== bench/tb_top.sv
/*
 Self-checking bench: registers over AHB-Lite, request latching, priority
 selection, global enable, traps and watchdog against a core model.
 Assumes zero-wait bus answers are still waited for, never counted.
*/
`timescale 1ns/100ps
module tb_top;
   localparam logic [11:0] rq [3] = vic_pkg::IDX_REQ;
   localparam logic [11:0] hi [3] = vic_pkg::IDX_PH;
   localparam logic [11:0] lo [3] = vic_pkg::IDX_PL;
   localparam logic [11:0] ct     = vic_pkg::IDX_CTRL;
   logic        clk, rstn, hsel, hwrite, hready, hresp, irq, gie, ack;
   logic        wdt_to, wdt_en;
   logic [1:0]  htrans, lag;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [15:0] vec, lvec;
   logic [0:23] src, q, ph, pl, fm, pv;
   logic [6:0]  ev;
   int          nack, err_total, n_tests, w;

   // ----------------------------------------------------------------
   // Clock, core model and design
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   core_model u_core (.clk_i(clk), .rstn_i(rstn), .req_i(irq), .vec_i(vec),
      .lag_i(lag), .ack_o(ack), .last_vec_o(lvec), .n_ack_o(nack));
   vectored_interrupt_controller u_dut (
      .CORE_CLK_I(clk), .RSTN_I(rstn), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
      .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
      .HREADYOUT_O(hready), .HRESP_O(hresp),
      .TIMER_ONE_REQUEST_I(src[1]), .TIMER_ZERO_REQUEST_I(src[2]),
      .SERIAL_RECEIVE_REQUEST_I(src[3]), .SERIAL_TRANSMIT_REQUEST_I(src[4]),
      .CONVERTER_REQUEST_I(src[7]), .PORTA_PIN7_OR_LOWVOLT_REQUEST_I(src[8]),
      .PORTA_PIN6_OR_COMPARATOR_REQUEST_I(src[9]),
      .PORTA_PIN_REQUEST_I(src[10:15]), .PORTC_PIN_REQUEST_I(src[20:23]),
      .WATCHDOG_TIMEOUT_I(wdt_to), .WATCHDOG_INT_ENABLE_I(wdt_en),
      .PRIMARY_OSC_FAIL_I(ev[1]), .WATCHDOG_OSC_FAIL_I(ev[0]),
      .ENABLE_INTERRUPTS_INSTRUCTION_I(ev[6]),
      .DISABLE_INTERRUPTS_INSTRUCTION_I(ev[4]),
      .RETURN_FROM_INTERRUPT_INSTRUCTION_I(ev[5]),
      .TRAP_INSTRUCTION_I(ev[3]), .ILLEGAL_INSTRUCTION_TRAP_I(ev[2]),
      .CORE_ACK_I(ack), .INT_REQUEST_O(irq), .INT_VECTOR_O(vec),
      .GLOBAL_INT_ENABLE_O(gie));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] ra(input logic [11:0] i);
      return {vic_pkg::ADDR_HI_ZERO, i, 2'h0};
   endfunction
   // Later passes win: higher level, then lower vector position
   function automatic int win(input logic [0:23] p, h, l);
      win = -1;
      for (int v = 1; v < 4; v++)
         for (int i = 23; i >= 0; i--)
            if (p[i] && {h[i], l[i]} == 2'(v)) win = i;
   endfunction
   task automatic chk(input string s, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic bus(input logic [31:0] a, input logic we,
                      input logic [7:0] d, input logic [0:23] p);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= we;
      htrans <= 2'h2;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, d};
      src <= p;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
      src <= '0;
      chk("response", {31'h0, vic_pkg::HRESP_OKAY}, {31'h0, hresp});
   endtask
   task automatic wr(input logic [11:0] i, input logic [7:0] d);
      bus(ra(i), 1'b1, d, '0);
   endtask
   task automatic rd(input string s, input logic [11:0] i,
                     input logic [7:0] e);
      bus(ra(i), 1'b0, 8'h00, '0);
      chk(s, {24'h00_0000, e}, r);
   endtask
   task automatic pulse(input logic [0:23] p, input logic [6:0] e);
      @(posedge clk);
      src <= p;
      ev <= e;
      @(posedge clk);
      src <= '0;
      ev <= '0;
   endtask
   // The wait is bounded so a missing ack shows up as a failed ack count
   task automatic await_ack(input logic [15:0] e);
      int n0;
      n0 = nack;
      for (int k = 0; k < 60 && nack == n0; k++) @(posedge clk);
      chk("ack seen", 32'(n0 + 1), 32'(nack));
      chk("ack vector", {16'h0000, e}, {16'h0000, lvec});
      @(posedge clk);
      chk("request and enable", 32'h0000_0000, {30'h0, irq, gie});
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (40000) @(posedge clk);
      err_total++;
      conclude();
   end
   initial begin
      {rstn, hsel, hwrite, wdt_to, wdt_en} = 5'h00;
      {haddr, hwdata, htrans, lag, src, ev} = '0;
      err_total = 0;
      n_tests = 0;
      fm = {vic_pkg::GROUP_MASK[0], vic_pkg::GROUP_MASK[1],
            vic_pkg::GROUP_MASK[2]};
      void'($urandom(32'h6454));
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      for (int g = 0; g < 3; g++) begin
         rd("request reset", rq[g], 8'h00);
         rd("high reset", hi[g], 8'h00);
         rd("low reset", lo[g], 8'h00);
         wr(rq[g], 8'hff);
         rd("request mask", rq[g], fm[8*g+:8]);
         wr(rq[g], 8'h00);
         rd("request clear", rq[g], 8'h00);
      end
      bus(32'h0001_0000, 1'b1, 8'hff, '0);
      bus(32'h0001_0000, 1'b0, 8'h00, '0);
      chk("unmapped", 32'h0000_0000, r);
      wr(ct, 8'h80);
      rd("enable set", ct, 8'h80);
      wr(ct, 8'h00);
      rd("enable clear", ct, 8'h00);
      // Disable, trap, illegal op and both oscillator fails
      for (int j = 0; j < 5; j++) begin
         wr(ct, 8'h80);
         pulse('0, 7'h10 >> j);
         @(posedge clk);
         chk("enable dropped", 32'h0000_0000, {31'h0, gie});
         if (j > 2)
            await_ack(j == 3 ? vic_pkg::VEC_POSC
                             : vic_pkg::VEC_WOSC);
      end
      bus(ra(rq[0]), 1'b1, 8'h00, 24'h40_0000);
      rd("hw beats write", rq[0], 8'h40);
      // Timeout without its enable must stay silent
      wdt_to <= 1'b1;
      wr(ct, 8'h80);
      repeat (4) @(posedge clk);
      chk("masked watchdog", 32'h0000_0000, {31'h0, irq});
      wr(ct, 8'h00);
      wr(hi[0], 8'h40);
      wr(lo[0], 8'h40);
      wdt_en <= 1'b1;
      wdt_to <= 1'b1;
      wr(ct, 8'h80);
      await_ack(vic_pkg::VEC_WDT);
      pulse('0, 7'h40);
      await_ack(vic_pkg::VEC_WDT);
      rd("bypassed bit", rq[0], 8'h40);
      wdt_to <= 1'b0;
      pulse('0, 7'h20);
      await_ack(vic_pkg::VEC_BASE + 16'h0002);
      for (int n = 0; n < 8; n++) begin
         for (int g = 0; g < 3; g++) begin
            {ph[8*g+:8], pl[8*g+:8], q[8*g+:8]} = 24'($urandom);
            wr(hi[g], ph[8*g+:8]);
            wr(lo[g], pl[8*g+:8]);
            wr(rq[g], q[8*g+:8]);
         end
         pv = 24'($urandom);
         pulse(pv, 7'h00);
         q = (q | pv) & fm;
         lag <= 2'($urandom);
         wr(ct, 8'h80);
         for (w = win(q, ph, pl); w >= 0; w = win(q, ph, pl)) begin
            await_ack(vic_pkg::VEC_BASE + 16'(2 * w));
            q[w] = 1'b0;
            for (int g = 0; g < 3; g++)
               rd("pending", rq[g], q[8*g+:8]);
            pulse('0, n[0] ? 7'h40 : 7'h20);
         end
         repeat (8) @(posedge clk);
         chk("idle request", 32'h0000_0000, {31'h0, irq});
         for (int g = 0; g < 3; g++) wr(rq[g], 8'h00);
         wr(ct, 8'h00);
      end
      conclude();
   end
endmodule
